// ---- bench/pecl_counter_bank_tb_top.sv ----
// testbench: counter bank checks driven through the management model
`default_nettype none

module pecl_counter_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int LIMIT = 90000;
  logic                    core_clk, arst_n, cyc, stb, we, ack, act, link, irq;
  logic [7:0]              adr;
  logic [3:0]              sel;
  logic [31:0]             wdat, rdat, d, seed;
  pecl_pkg::pecl_evt_t     evt;
  pecl_pkg::pecl_led_src_t led_src;
  logic [31:0]             exp_q[$];
  int                      n_errors, check_count, cycles, n, k;

  pecl_mgmt_model i_mgmt (.core_clk(core_clk), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));

  pecl_counter_bank i_dut (.core_clk(core_clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .phy_evt(evt),
    .led_src(led_src), .activity_indicator_out(act), .link_indicator_out(link), .irq(irq));

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
    return seed;
  endfunction : rnd

  function automatic logic [1:0] led_exp(input logic [2:0] m, input logic [3:0] s);
    case (m)
      3'h0: return {s[3], s[2]};
      3'h1: return {s[1], s[0]};
      3'h2: return {s[1], s[2]};
      3'h3: return {s[3], s[0]};
      default: return m[1:0];
    endcase
  endfunction : led_exp

  task automatic compare(input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : compare

  task automatic compare_pins(input logic [1:0] exp, input logic [1:0] got);
    compare({30'h0, exp}, {30'h0, got});
  endtask : compare_pins

  task automatic wr(input logic [5:0] idx, input logic [15:0] v);
    logic [31:0] q;
    i_mgmt.access(1'b1, idx, v, q);
  endtask : wr

  task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    exp_q.push_back(exp);
    i_mgmt.access(1'b0, idx, 16'h0, q);
  endtask : rd

  // each event value stands for n cycles, then the lines go idle
  task automatic hold_evt(input logic [6:0] v, input int cnt);
    @(posedge core_clk);
    evt <= v;
    repeat (cnt) @(posedge core_clk);
    evt <= 7'h00;
  endtask : hold_evt

  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test

  // read data is judged when the answer shows up, against the oldest note
  always @(posedge core_clk)
  begin
    if (ack === 1'b1 && cyc === 1'b1 && we === 1'b0 && exp_q.size() > 0)
      compare(exp_q.pop_front(), rdat);
  end

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      n_errors++;
      finish_test();
    end
  end

  initial
  begin
    seed = 32'hFAD341C4;
    arst_n = 1'b0;
    evt = 7'h00;
    led_src = 4'h0;
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    for (int i = 8'h14; i <= 8'h1B; i++)
      rd(i[5:0], 32'h0);
    wr(6'h3F, 16'hBEEF);
    rd(6'h3F, 32'h0);
    wr(pecl_pkg::IDX_IRQ_MASK, 16'h0020);
    hold_evt(7'h01, 1);
    repeat (3) @(posedge core_clk);
    compare_pins(2'b01, {1'b0, irq});
    rd(pecl_pkg::IDX_IRQ_STAT, 32'h20);
    repeat (2) @(posedge core_clk);
    compare_pins(2'b00, {1'b0, irq});
    hold_evt(7'h02, 1);
    repeat (3) @(posedge core_clk);
    compare_pins(2'b00, {1'b0, irq});
    rd(pecl_pkg::IDX_IRQ_STAT, 32'h10);
    rd(pecl_pkg::IDX_JABBER, 32'h1);
    rd(pecl_pkg::IDX_SLOW_EOF, 32'h1);
    n = 1 + int'(rnd() % 14);
    k = 1 + int'(rnd() % 8);
    hold_evt(7'h38, n);
    hold_evt(7'h24, 2);
    hold_evt(7'h40, k);
    hold_evt(7'h03, k);
    wr(pecl_pkg::IDX_JABBER, 16'h1234);
    wr(pecl_pkg::IDX_SLOW_EOF, 16'hFFFF);
    rd(pecl_pkg::IDX_SYM_ERR, 32'((n + 5) / 6));
    rd(pecl_pkg::IDX_SYM_ERR, 32'h0);
    rd(pecl_pkg::IDX_ERR_FRAME, 32'h2);
    rd(pecl_pkg::IDX_EARLY_END, 32'h2);
    rd(pecl_pkg::IDX_DISC, 32'(k));
    rd(pecl_pkg::IDX_SLOW_EOF, 32'(k));
    rd(pecl_pkg::IDX_JABBER, 32'(k));
    rd(pecl_pkg::IDX_JABBER, 32'h0);
    // disconnect and jabber both run past full to exercise saturation
    hold_evt(7'h41, 65540);
    rd(pecl_pkg::IDX_DISC, 32'hFFFF);
    rd(pecl_pkg::IDX_DISC, 32'h0);
    rd(pecl_pkg::IDX_JABBER, 32'hFFFF);
    d = rnd();
    wr(pecl_pkg::IDX_EQ_RSVD, d[15:0]);
    rd(pecl_pkg::IDX_EQ_RSVD, {16'h0, d[15:0]});
    for (int m = 0; m < 8; m++)
    begin
      d = rnd();
      led_src <= d[3:0];
      wr(pecl_pkg::IDX_LED_SEL, {13'h1FFF, m[2:0]});
      repeat (2) @(posedge core_clk);
      compare_pins(led_exp(m[2:0], d[3:0]), {act, link});
      rd(pecl_pkg::IDX_LED_SEL, 32'(m));
    end
    repeat (2) @(posedge core_clk);
    finish_test();
  end
endmodule : pecl_counter_bank_tb_top

`default_nettype wire

// ---- bench/pecl_mgmt_model.sv ----
// station management model: classic wishbone master with a blocking access task
`default_nettype none

module pecl_mgmt_model (
  input  wire logic        core_clk,
  output var  logic        wb_cyc_i,
  output var  logic        wb_stb_i,
  output var  logic        wb_we_i,
  output var  logic [7:0]  wb_adr_i,
  output var  logic [3:0]  wb_sel_i,
  output var  logic [31:0] wb_dat_i,
  input  wire logic [31:0] wb_dat_o,
  input  wire logic        wb_ack_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i  = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h3;
    wb_dat_i = 32'h0;
  end

  task automatic access(input logic we, input logic [5:0] idx, input logic [15:0] d, output logic [31:0] q);
    begin
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= {idx, 2'b00};
      wb_dat_i <= {16'h0, (idx == pecl_pkg::IDX_LED_SEL) ? {13'h0, d[2:0]} : d};
      @(posedge core_clk);
      while (wb_ack_o !== 1'b1)
        @(posedge core_clk);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      // released lines stop showing the old request
      wb_adr_i <= ~wb_adr_i;
      wb_dat_i <= ~wb_dat_i;
    end
  endtask : access
endmodule : pecl_mgmt_model

`default_nettype wire

// ---- logic/pecl_counter_bank.sv ----
// module: wishbone register bank with saturating clear-on-read error counters and led selection
//
// Local design decision: the Wishbone interface to the registers.
`default_nettype none

module pecl_counter_bank (
  input  wire logic                  core_clk,
  input  wire logic                  arst_n,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output var  logic [31:0]           wb_dat_o,
  output var  logic                  wb_ack_o,
  input  wire pecl_pkg::pecl_evt_t   phy_evt,
  input  wire pecl_pkg::pecl_led_src_t led_src,
  output var  logic                  activity_indicator_out,
  output var  logic                  link_indicator_out,
  output var  logic                  irq
);

  logic [pecl_pkg::CNT_W-1:0]   cnt [pecl_pkg::NUM_CNT];
  logic [pecl_pkg::NUM_CNT-1:0] evt;
  logic [pecl_pkg::NUM_CNT-1:0] rd_clr;
  logic [pecl_pkg::NUM_CNT-1:0] irq_stat;
  logic [pecl_pkg::NUM_CNT-1:0] irq_mask;
  logic [2:0]                   sym_run;
  logic                         frame_err_seen;
  logic                         sym_hit;
  logic                         frame_err_in;
  logic                         req;
  logic                         rd_take;
  logic                         wr_take;
  logic [5:0]                   idx;
  logic [15:0]                  eq_rsvd;
  pecl_pkg::pecl_led_mode_t     led_sel;
  logic [31:0]                  next_rdata;

  // saturating step; a clear plus an event in the same cycle leaves one count
  function automatic logic [pecl_pkg::CNT_W-1:0] sat_step(
    input logic [pecl_pkg::CNT_W-1:0] cur,
    input logic                       inc,
    input logic                       clr
  );
    logic [pecl_pkg::CNT_W-1:0] base;
    base = clr ? pecl_pkg::CNT_RST : cur;
    if (inc && base != pecl_pkg::CNT_FULL)
      sat_step = base + 16'h0001;
    else
      sat_step = base;
  endfunction : sat_step

  function automatic logic [15:0] byte_merge(
    input logic [15:0] cur,
    input logic [15:0] wdata,
    input logic [1:0]  sel
  );
    byte_merge = cur;
    if (sel[0])
      byte_merge[7:0] = wdata[7:0];
    if (sel[1])
      byte_merge[15:8] = wdata[15:8];
  endfunction : byte_merge

  assign idx     = wb_adr_i[7:2];
  assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign rd_take = req & ~wb_we_i;
  assign wr_take = req & wb_we_i;

  // symbol errors only matter inside a frame
  assign sym_hit      = phy_evt.rx_frame_active & phy_evt.rx_symbol_strobe & phy_evt.rx_symbol_bad;
  assign frame_err_in = phy_evt.rx_frame_active & (sym_hit | phy_evt.rx_early_end);

  always_comb
  begin
    evt = '0;
    // (R01) disconnect event
    evt[pecl_pkg::CNT_DISC]      = phy_evt.rx_disconnect;
    // (R02) first error of a frame only
    evt[pecl_pkg::CNT_ERR_FRAME] = frame_err_in & ~frame_err_seen;
    // (R03) (R04) one count per run of six
    evt[pecl_pkg::CNT_SYM_ERR]   = sym_hit & (sym_run == 3'h0);
    // (R05) premature end of frame
    evt[pecl_pkg::CNT_EARLY_END] = phy_evt.rx_early_end;
    // (R06) slow end of frame error
    evt[pecl_pkg::CNT_SLOW_EOF]  = phy_evt.slow_frame_end_err;
    // (R07) transmit jabber
    evt[pecl_pkg::CNT_JABBER]    = phy_evt.tx_jabber;
  end

  // (R08) read clears the counter it hits
  always_comb
  begin
    rd_clr = '0;
    for (int i = 0; i < pecl_pkg::NUM_CNT; i++)
      rd_clr[i] = rd_take && (idx == pecl_pkg::IDX_DISC + 6'(i));
  end

  // (R04) run position within consecutive bad symbols
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      sym_run <= 3'h0;
    else if (phy_evt.rx_symbol_strobe)
    begin
      if (!sym_hit || sym_run == pecl_pkg::SYM_RUN_LEN - 3'h1)
        sym_run <= 3'h0;
      else
        sym_run <= sym_run + 3'h1;
    end
    else if (!phy_evt.rx_frame_active)
      sym_run <= 3'h0;
  end

  // (R02) remembers that this frame is already counted
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      frame_err_seen <= 1'b0;
    else if (!phy_evt.rx_frame_active)
      frame_err_seen <= 1'b0;
    else if (frame_err_in)
      frame_err_seen <= 1'b1;
  end

  // (R08) (R12) saturating counters, writes never reach them
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < pecl_pkg::NUM_CNT; i++)
        cnt[i] <= pecl_pkg::CNT_RST;
    end
    else
    begin
      for (int i = 0; i < pecl_pkg::NUM_CNT; i++)
        cnt[i] <= sat_step(cnt[i], evt[i], rd_clr[i]);
    end
  end

  // (R11) free read-write field
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      eq_rsvd <= pecl_pkg::EQ_RST;
    else if (wr_take && idx == pecl_pkg::IDX_EQ_RSVD)
      eq_rsvd <= byte_merge(eq_rsvd, wb_dat_i[15:0], wb_sel_i[1:0]);
  end

  // (R09) (R10) only the selector is stored, upper bits stay zero
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      led_sel <= pecl_pkg::LED_SEL_RST;
    else if (wr_take && idx == pecl_pkg::IDX_LED_SEL && wb_sel_i[0])
      led_sel <= pecl_pkg::pecl_led_mode_t'(wb_dat_i[pecl_pkg::LED_SEL_W-1:0]);
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      irq_mask <= pecl_pkg::IRQ_MASK_RST;
    else if (wr_take && idx == pecl_pkg::IDX_IRQ_MASK && wb_sel_i[0])
      irq_mask <= wb_dat_i[pecl_pkg::NUM_CNT-1:0];
  end

  // sticky status; an event in the clearing read's cycle survives
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      irq_stat <= '0;
    else if (rd_take && idx == pecl_pkg::IDX_IRQ_STAT)
      irq_stat <= evt;
    else
      irq_stat <= irq_stat | evt;
  end

  // registered so the pin never glitches; costs one cycle of latency
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      irq <= 1'b0;
    else
      irq <= |(irq_stat & irq_mask);
  end

  // (R09) led source selection
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      activity_indicator_out <= 1'b0;
      link_indicator_out     <= 1'b0;
    end
    else
    begin
      unique case (led_sel)
        pecl_pkg::LED_ACT_LINK:
        begin
          activity_indicator_out <= led_src.activity;
          link_indicator_out     <= led_src.link;
        end
        pecl_pkg::LED_SPD_COL:
        begin
          activity_indicator_out <= led_src.speed;
          link_indicator_out     <= led_src.collision;
        end
        pecl_pkg::LED_SPD_LINK:
        begin
          activity_indicator_out <= led_src.speed;
          link_indicator_out     <= led_src.link;
        end
        pecl_pkg::LED_ACT_COL:
        begin
          activity_indicator_out <= led_src.activity;
          link_indicator_out     <= led_src.collision;
        end
        pecl_pkg::LED_OFF_OFF:
        begin
          activity_indicator_out <= 1'b0;
          link_indicator_out     <= 1'b0;
        end
        pecl_pkg::LED_OFF_ON:
        begin
          activity_indicator_out <= 1'b0;
          link_indicator_out     <= 1'b1;
        end
        pecl_pkg::LED_ON_OFF:
        begin
          activity_indicator_out <= 1'b1;
          link_indicator_out     <= 1'b0;
        end
        pecl_pkg::LED_ON_ON:
        begin
          activity_indicator_out <= 1'b1;
          link_indicator_out     <= 1'b1;
        end
      endcase
    end
  end

  // read data shows the value before any clear of the same edge
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (idx >= pecl_pkg::IDX_DISC && idx <= pecl_pkg::IDX_JABBER)
      next_rdata[15:0] = cnt[3'(idx - pecl_pkg::IDX_DISC)];
    else if (idx == pecl_pkg::IDX_EQ_RSVD)
      next_rdata[15:0] = eq_rsvd;
    else if (idx == pecl_pkg::IDX_LED_SEL)
      next_rdata[pecl_pkg::LED_SEL_W-1:0] = led_sel;
    else if (idx == pecl_pkg::IDX_IRQ_STAT)
      next_rdata[pecl_pkg::NUM_CNT-1:0] = irq_stat;
    else if (idx == pecl_pkg::IDX_IRQ_MASK)
      next_rdata[pecl_pkg::NUM_CNT-1:0] = irq_mask;
  end

  // every access is answered, unmapped ones read zero
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= req;
      if (rd_take)
        wb_dat_o <= next_rdata;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  property p_disc_inc;
    evt[pecl_pkg::CNT_DISC] && !rd_clr[pecl_pkg::CNT_DISC] && cnt[pecl_pkg::CNT_DISC] != pecl_pkg::CNT_FULL
      |=> cnt[pecl_pkg::CNT_DISC] == $past(cnt[pecl_pkg::CNT_DISC]) + 16'h0001;
  endproperty
  a_disc_inc: assert property (p_disc_inc) else $error("disconnect counter did not step"); // (R01)

  property p_frame_once;
    frame_err_seen && phy_evt.rx_frame_active && !rd_clr[pecl_pkg::CNT_ERR_FRAME]
      |=> $stable(cnt[pecl_pkg::CNT_ERR_FRAME]);
  endproperty
  a_frame_once: assert property (p_frame_once) else $error("frame error counted twice"); // (R02)

  property p_sym_run;
    sym_hit && sym_run != 3'h0 && !rd_clr[pecl_pkg::CNT_SYM_ERR] |=> $stable(cnt[pecl_pkg::CNT_SYM_ERR]);
  endproperty
  a_sym_run: assert property (p_sym_run) else $error("symbol run counted more than once"); // (R04)

  property p_sym_first;
    sym_hit && sym_run == 3'h0 && !rd_clr[pecl_pkg::CNT_SYM_ERR] && cnt[pecl_pkg::CNT_SYM_ERR] != pecl_pkg::CNT_FULL
      |=> cnt[pecl_pkg::CNT_SYM_ERR] != $past(cnt[pecl_pkg::CNT_SYM_ERR]);
  endproperty
  a_sym_first: assert property (p_sym_first) else $error("symbol error missed"); // (R03)

  property p_jab_sat;
    cnt[pecl_pkg::CNT_JABBER] == pecl_pkg::CNT_FULL && !rd_clr[pecl_pkg::CNT_JABBER]
      |=> cnt[pecl_pkg::CNT_JABBER] == pecl_pkg::CNT_FULL;
  endproperty
  a_jab_sat: assert property (p_jab_sat) else $error("jabber counter wrapped"); // (R08)

  property p_clr_read;
    rd_clr[pecl_pkg::CNT_EARLY_END] && !evt[pecl_pkg::CNT_EARLY_END]
      |=> cnt[pecl_pkg::CNT_EARLY_END] == pecl_pkg::CNT_RST && wb_ack_o;
  endproperty
  a_clr_read: assert property (p_clr_read) else $error("read did not clear counter"); // (R05)

  property p_slow_wr;
    wr_take && idx == pecl_pkg::IDX_SLOW_EOF && !evt[pecl_pkg::CNT_SLOW_EOF] |=> $stable(cnt[pecl_pkg::CNT_SLOW_EOF]);
  endproperty
  a_slow_wr: assert property (p_slow_wr) else $error("write changed a counter"); // (R06)

  property p_led_off;
    led_sel == pecl_pkg::LED_OFF_ON ##1 led_sel == pecl_pkg::LED_OFF_ON
      |-> !activity_indicator_out && link_indicator_out;
  endproperty
  a_led_off: assert property (p_led_off) else $error("led fixed mode wrong"); // (R09)

  property p_led_rsvd;
    wb_ack_o && !wb_we_i && $past(idx) == pecl_pkg::IDX_LED_SEL |-> wb_dat_o[31:3] == 29'h0;
  endproperty
  a_led_rsvd: assert property (p_led_rsvd) else $error("led reserved bits not zero"); // (R10)

  property p_ack_one;
    req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack not a single cycle"); // local design decision: single-cycle Wishbone ack

endmodule : pecl_counter_bank

`default_nettype wire

// ---- logic/pecl_pkg.sv ----
// package: register map, field layout, event carriers and led modes for the phy error counter bank
// Operation
// (R01) A 16-bit counter at register 20 counts every 100 Mb/s receive disconnect event.
// (R02) A 16-bit counter at register 21 counts each received frame holding any receive error exactly once.
// (R03) A 16-bit counter at register 22 counts detected receive symbol errors.
// (R04) Inside an errored frame each run of six consecutive bad symbols adds only one to the symbol error count.
// (R05) A 16-bit counter at register 23 counts every 100 Mb/s receive premature end of frame event.
// (R06) A 16-bit counter at register 24 counts every 10 Mb/s receive end of frame error event.
// (R07) A 16-bit counter at register 25 counts every 10 Mb/s transmit jabber event.
// (R08) Counters 20 to 25 stop at all ones, clear when management reads them, and ignore writes.
// (R09) A 3-bit selector in bits 2:0 of register 27, reset to 000, picks what the two led outputs show.
// (R10) Management writes zeros to bits 15:3 of register 27, and the device resets them to zero.
// (R11) Register 26 is a plain 16-bit read-write field with no function.
// (R12) All event counters start from zero after reset.
`default_nettype none

package pecl_pkg;

  localparam int CNT_W   = 16;
  localparam int NUM_CNT = 6;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_DISC      = 6'h14;
  localparam logic [5:0] IDX_ERR_FRAME = 6'h15;
  localparam logic [5:0] IDX_SYM_ERR   = 6'h16;
  localparam logic [5:0] IDX_EARLY_END = 6'h17;
  localparam logic [5:0] IDX_SLOW_EOF  = 6'h18;
  localparam logic [5:0] IDX_JABBER    = 6'h19;
  localparam logic [5:0] IDX_EQ_RSVD   = 6'h1A;
  localparam logic [5:0] IDX_LED_SEL   = 6'h1B;
  localparam logic [5:0] IDX_IRQ_STAT  = 6'h1C;
  localparam logic [5:0] IDX_IRQ_MASK  = 6'h1D;

  // counter slots, also the bit positions in the interrupt status and mask
  localparam int CNT_DISC      = 0;
  localparam int CNT_ERR_FRAME = 1;
  localparam int CNT_SYM_ERR   = 2;
  localparam int CNT_EARLY_END = 3;
  localparam int CNT_SLOW_EOF  = 4;
  localparam int CNT_JABBER    = 5;

  localparam logic [CNT_W-1:0]   CNT_RST      = 16'h0000;
  localparam logic [CNT_W-1:0]   CNT_FULL     = 16'hFFFF;
  localparam logic [15:0]        EQ_RST       = 16'h0000;
  localparam logic [NUM_CNT-1:0] IRQ_MASK_RST = 6'h00;
  localparam logic [2:0]         SYM_RUN_LEN  = 3'h6;
  localparam int                 LED_SEL_W    = 3;

  typedef enum logic [2:0] {
    LED_ACT_LINK = 3'b000,
    LED_SPD_COL  = 3'b001,
    LED_SPD_LINK = 3'b010,
    LED_ACT_COL  = 3'b011,
    LED_OFF_OFF  = 3'b100,
    LED_OFF_ON   = 3'b101,
    LED_ON_OFF   = 3'b110,
    LED_ON_ON    = 3'b111
  } pecl_led_mode_t;

  localparam pecl_led_mode_t LED_SEL_RST = LED_ACT_LINK;

  // event strobes from the receive and transmit paths, all on core_clk
  typedef struct packed {
    logic rx_disconnect;
    logic rx_frame_active;
    logic rx_symbol_strobe;
    logic rx_symbol_bad;
    logic rx_early_end;
    logic slow_frame_end_err;
    logic tx_jabber;
  } pecl_evt_t;

  typedef struct packed {
    logic activity;
    logic link;
    logic speed;
    logic collision;
  } pecl_led_src_t;

endpackage : pecl_pkg

`default_nettype wire
